// ==== csp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module csp_host_model (
  input wire logic i_clock,
  input wire logic i_shift_clock,
  input wire logic i_tx_frame_sync_n,
  input wire logic i_rx_frame_sync_n,
  input wire logic i_serial_data_out,
  input wire logic [15:0] i_tx_word,
  output logic o_serial_data_in,
  output logic [15:0] o_rx_word
);
  logic sclk_q = 1'b0;
  logic [15:0] sh = 16'h0000;
  logic [4:0] cnt = 5'h00;
  initial o_serial_data_in = 1'b0;
  initial o_rx_word = 16'h0000;
  // ****************
  // host port, acts one clock after each shift clock rise
  // ****************
  always @(posedge i_clock) begin
    sclk_q <= i_shift_clock;
    if (i_shift_clock && !sclk_q) begin
      if (!i_tx_frame_sync_n) begin
        o_serial_data_in <= sh[15];
        sh <= {sh[14:0], 1'b0};
        cnt <= cnt + 5'h01;
      end else begin
        // released line toggles, no stale bit
        o_serial_data_in <= !o_serial_data_in;
        if (cnt != 5'h08) begin
          sh <= i_tx_word;
          cnt <= 5'h00;
        end
      end
      if (!i_rx_frame_sync_n) begin
        o_rx_word <= {o_rx_word[14:0], i_serial_data_out};
      end
    end
  end
endmodule // csp_host_model
`default_nettype wire

// ==== csp_pkg.sv ====
package csp_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CSP_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] CSP_ADDR_TX_DIVIDER_A = 8'h04;
  localparam logic [7:0] CSP_ADDR_TX_RATE_ADJUST = 8'h08;
  localparam logic [7:0] CSP_ADDR_TX_DIVIDER_B = 8'h0C;
  localparam logic [7:0] CSP_ADDR_RX_DIVIDER_A = 8'h10;
  localparam logic [7:0] CSP_ADDR_RX_RATE_ADJUST = 8'h14;
  localparam logic [7:0] CSP_ADDR_RX_DIVIDER_B = 8'h18;
  localparam logic [7:0] CSP_ADDR_ADC_WORD = 8'h1C;
  localparam logic [7:0] CSP_ADDR_DAC_WORD = 8'h20;
  localparam logic [7:0] CSP_ADDR_STATUS = 8'h24;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int unsigned CSP_CTRL_SYNC_BIT = 5;
  localparam int unsigned CSP_CMD_SECONDARY_BIT = 0;
  localparam int unsigned CSP_ST_WORD_BIT = 0;
  localparam int unsigned CSP_ST_TX_BUSY_BIT = 1;
  localparam int unsigned CSP_ST_RX_BUSY_BIT = 2;
  localparam int unsigned CSP_ST_DAC_NEW_BIT = 3;
  localparam int unsigned CSP_ST_SEC_PEND_BIT = 4;
  localparam logic [7:0] CSP_RST_CONTROL = 8'hE4;
  localparam logic [7:0] CSP_RST_DIVIDER_A = 8'h12;
  localparam logic [7:0] CSP_RST_DIVIDER_B = 8'h24;
  localparam logic [7:0] CSP_RST_RATE_ADJUST = 8'h01;

  // ****************************************************************
  // serial timing
  // ****************************************************************
  localparam logic [1:0] CSP_SHIFT_PHASE_LAST = 2'h3;
  localparam logic [1:0] CSP_SHIFT_PHASE_HIGH = 2'h2;
  localparam logic [4:0] CSP_WORD_BITS = 5'h10;
  localparam logic [4:0] CSP_BYTE_BITS = 5'h08;
  localparam logic [4:0] CSP_GAP_CLOCKS = 5'h04;

  typedef enum logic [5:0] {
    CSP_ES_IDLE = 6'b000001,
    CSP_ES_LOAD = 6'b000010,
    CSP_ES_SHIFT1 = 6'b000100,
    CSP_ES_GAP = 6'b001000,
    CSP_ES_SHIFT2 = 6'b010000,
    CSP_ES_DONE = 6'b100000
  } csp_est_t;

  typedef struct packed {
    csp_est_t st;
    logic [4:0] cnt;
    logic fs_n;
    logic eod_n;
    logic bmode;
    logic [15:0] sh;
  } csp_eng_t;

  typedef struct packed {
    logic [1:0] ph;
    logic shclk;
    logic ws_s1;
    logic ws_s2;
    logic din_s1;
    logic din_s2;
    csp_eng_t tx;
    csp_eng_t rx;
    logic tx_pend;
    logic rx_pend;
    logic sec_pend;
    logic [7:0] ctrl;
    logic [7:0] tx_div_a;
    logic [7:0] tx_adj;
    logic [7:0] tx_div_b;
    logic [7:0] rx_div_a;
    logic [7:0] rx_adj;
    logic [7:0] rx_div_b;
    logic tx_adj_pend;
    logic rx_adj_pend;
    logic [7:0] tx_cnt_a;
    logic [7:0] tx_cnt_b;
    logic [7:0] rx_cnt_a;
    logic [7:0] rx_cnt_b;
    logic tx_filt;
    logic rx_filt;
    logic tx_conv;
    logic rx_conv;
    logic [15:0] adc_word;
    logic [15:0] dac_word;
    logic dac_new;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csp_state_t;

endpackage

// ==== csp_serial_port.sv ====
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module csp_serial_port
  import csp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_word_select,
  input wire logic i_serial_data_in,
  output logic o_shift_clock,
  output logic o_serial_data_out,
  output logic o_tx_frame_sync_n,
  output logic o_rx_frame_sync_n,
  output logic o_tx_transfer_done_n,
  output logic o_rx_transfer_done_n,
  output logic o_tx_filter_tick,
  output logic o_rx_filter_tick,
  output logic o_tx_convert,
  output logic o_rx_convert
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // counter A period, with a pending one-shot adjust folded in
  function automatic logic [7:0] a_period(input logic [7:0] div, input logic [7:0] adj,
                                          input logic pend);
    logic [7:0] p;
    p = pend ? 8'(div + adj) : div;
    if (p == 8'h00) begin
      p = 8'h01;
    end
    return p;
  endfunction

  function automatic logic wrap_hit(input logic [7:0] cnt, input logic [7:0] period);
    return (period == 8'h00) || (cnt >= 8'(period - 8'h01));
  endfunction

  function automatic logic eng_last(input csp_eng_t e);
    logic lst;
    lst = 1'b0;
    if (e.st == CSP_ES_SHIFT1) begin
      lst = !e.bmode && (e.cnt == 5'(CSP_WORD_BITS - 5'h01));
    end else if (e.st == CSP_ES_SHIFT2) begin
      lst = (e.cnt == 5'(CSP_BYTE_BITS - 5'h01));
    end
    return lst;
  endfunction

  // one shift clock step of a frame engine
  function automatic csp_eng_t eng_step(input csp_eng_t e, input logic start,
                                        input logic [15:0] word, input logic bmode,
                                        input logic din);
    csp_eng_t n;
    logic [4:0] nbits;
    n = e;
    nbits = e.bmode ? CSP_BYTE_BITS : CSP_WORD_BITS;
    case (e.st)
      CSP_ES_IDLE: begin
        if (start) begin
          n.sh = word; // MSB on the line a shift clock ahead of the sync
          n.bmode = bmode;
          n.cnt = 5'h00;
          n.st = CSP_ES_LOAD;
        end
      end
      CSP_ES_LOAD: begin
        n.fs_n = 1'b0;
        n.st = CSP_ES_SHIFT1;
      end
      CSP_ES_SHIFT1: begin
        n.sh = {e.sh[14:0], din};
        n.cnt = 5'(e.cnt + 5'h01);
        if (e.cnt == 5'(nbits - 5'h01)) begin
          n.cnt = 5'h00;
          n.fs_n = 1'b1;
          if (e.bmode) begin
            n.eod_n = 1'b0;
            n.st = CSP_ES_GAP;
          end else begin
            n.st = CSP_ES_DONE;
          end
        end
      end
      CSP_ES_GAP: begin
        n.cnt = 5'(e.cnt + 5'h01);
        if (e.cnt == 5'(CSP_GAP_CLOCKS - 5'h01)) begin
          n.cnt = 5'h00;
          n.fs_n = 1'b0;
          n.st = CSP_ES_SHIFT2;
        end
      end
      CSP_ES_SHIFT2: begin
        n.sh = {e.sh[14:0], din};
        n.cnt = 5'(e.cnt + 5'h01);
        if (e.cnt == 5'(CSP_BYTE_BITS - 5'h01)) begin
          n.cnt = 5'h00;
          n.eod_n = 1'b1;
          n.fs_n = 1'b1;
          n.st = CSP_ES_IDLE;
        end
      end
      CSP_ES_DONE: begin
        // frame sync already high; one shift clock of low strobe
        if (e.cnt == 5'h00) begin
          n.eod_n = 1'b0;
          n.cnt = 5'h01;
        end else begin
          n.eod_n = 1'b1;
          n.cnt = 5'h00;
          n.st = CSP_ES_IDLE;
        end
      end
      default: begin
        n.st = CSP_ES_IDLE;
        n.fs_n = 1'b1;
        n.eod_n = 1'b1;
        n.cnt = 5'h00;
      end
    endcase
    return n;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  csp_state_t s_q;
  csp_state_t s_d;

  logic tick;
  logic sync_mode;
  logic tx_start;
  logic tx_primary;
  logic rx_start;
  logic tx_a_hit;
  logic tx_b_hit;
  logic rx_a_hit;
  logic rx_b_hit;
  logic setup;
  logic wr;
  logic rd_done;
  logic [31:0] rdata;
  logic rhit;

  assign tick = (s_q.ph == CSP_SHIFT_PHASE_LAST);
  assign sync_mode = s_q.ctrl[CSP_CTRL_SYNC_BIT];
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && s_q.pready && i_pwrite;
  assign rd_done = i_psel && i_penable && s_q.pready && !i_pwrite;
  assign tx_a_hit = wrap_hit(s_q.tx_cnt_a, a_period(s_q.tx_div_a, s_q.tx_adj, s_q.tx_adj_pend));
  assign tx_b_hit = wrap_hit(s_q.tx_cnt_b, s_q.tx_div_b);
  assign rx_a_hit = wrap_hit(s_q.rx_cnt_a, a_period(s_q.rx_div_a, s_q.rx_adj, s_q.rx_adj_pend));
  assign rx_b_hit = wrap_hit(s_q.rx_cnt_b, s_q.rx_div_b);
  assign tx_start = tick && (s_q.tx.st == CSP_ES_IDLE) && (s_q.tx_pend || s_q.sec_pend);
  assign tx_primary = s_q.tx_pend;
  // sync mode: rx frame only on primary, in step with tx
  assign rx_start = sync_mode ? (tx_start && tx_primary)
                              : (tick && (s_q.rx.st == CSP_ES_IDLE) && s_q.rx_pend);

  // ****************************************************************
  // register read decode
  // ****************************************************************
  always_comb begin
    rhit = 1'b1;
    rdata = 32'h0000_0000;
    case (i_paddr)
      CSP_ADDR_CONTROL: rdata[7:0] = s_q.ctrl;
      CSP_ADDR_TX_DIVIDER_A: rdata[7:0] = s_q.tx_div_a;
      CSP_ADDR_TX_RATE_ADJUST: rdata[7:0] = s_q.tx_adj;
      CSP_ADDR_TX_DIVIDER_B: rdata[7:0] = s_q.tx_div_b;
      CSP_ADDR_RX_DIVIDER_A: rdata[7:0] = s_q.rx_div_a;
      CSP_ADDR_RX_RATE_ADJUST: rdata[7:0] = s_q.rx_adj;
      CSP_ADDR_RX_DIVIDER_B: rdata[7:0] = s_q.rx_div_b;
      CSP_ADDR_ADC_WORD: rdata[15:0] = s_q.adc_word;
      CSP_ADDR_DAC_WORD: rdata[15:0] = s_q.dac_word;
      CSP_ADDR_STATUS: begin
        rdata[CSP_ST_WORD_BIT] = s_q.ws_s2;
        rdata[CSP_ST_TX_BUSY_BIT] = (s_q.tx.st != CSP_ES_IDLE);
        rdata[CSP_ST_RX_BUSY_BIT] = (s_q.rx.st != CSP_ES_IDLE);
        rdata[CSP_ST_DAC_NEW_BIT] = s_q.dac_new;
        rdata[CSP_ST_SEC_PEND_BIT] = s_q.sec_pend;
      end
      default: rhit = 1'b0;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // shift clock: master divided by four, rises with the frame updates
    s_d.ph = 2'(s_q.ph + 2'h1);
    s_d.shclk = (s_d.ph < CSP_SHIFT_PHASE_HIGH);
    s_d.ws_s1 = i_word_select;
    s_d.ws_s2 = s_q.ws_s1;
    s_d.din_s1 = i_serial_data_in;
    s_d.din_s2 = s_q.din_s1;

    // ****************************************************************
    // filter and conversion timing
    // ****************************************************************
    // tx filter and conversion timing
    s_d.tx_filt = 1'b0;
    s_d.tx_conv = 1'b0;
    s_d.tx_cnt_a = 8'(s_q.tx_cnt_a + 8'h01);
    if (tx_a_hit) begin
      s_d.tx_cnt_a = 8'h00;
      s_d.tx_filt = 1'b1;
      s_d.tx_adj_pend = 1'b0;
      s_d.tx_cnt_b = 8'(s_q.tx_cnt_b + 8'h01);
      if (tx_b_hit) begin
        s_d.tx_cnt_b = 8'h00;
        s_d.tx_conv = 1'b1;
      end
    end

    // rx timing: own counters only when asynchronous
    s_d.rx_filt = 1'b0;
    s_d.rx_conv = 1'b0;
    if (sync_mode) begin
      s_d.rx_cnt_a = 8'h00;
      s_d.rx_cnt_b = 8'h00;
      s_d.rx_filt = s_d.tx_filt;
      s_d.rx_conv = s_d.tx_conv;
    end else begin
      s_d.rx_cnt_a = 8'(s_q.rx_cnt_a + 8'h01);
      if (rx_a_hit) begin
        s_d.rx_cnt_a = 8'h00;
        s_d.rx_filt = 1'b1;
        s_d.rx_adj_pend = 1'b0;
        s_d.rx_cnt_b = 8'(s_q.rx_cnt_b + 8'h01);
        if (rx_b_hit) begin
          s_d.rx_cnt_b = 8'h00;
          s_d.rx_conv = 1'b1;
        end
      end
    end

    // frame requests; a new request wins over the clear
    s_d.tx_pend = (s_q.tx_pend && !(tx_start && tx_primary)) || s_q.tx_conv;
    s_d.rx_pend = sync_mode ? 1'b0 : ((s_q.rx_pend && !rx_start) || s_q.rx_conv);
    s_d.sec_pend = s_q.sec_pend && !(tx_start && !tx_primary);

    // frame engines
    if (tick) begin
      s_d.tx = eng_step(s_q.tx, tx_start, 16'h0000, !s_q.ws_s2, s_q.din_s2);
      s_d.rx = eng_step(s_q.rx, rx_start, s_q.adc_word, !s_q.ws_s2, 1'b0);
    end

    // received word from the host
    s_d.dac_new = s_q.dac_new && !(rd_done && (i_paddr == CSP_ADDR_DAC_WORD));
    if (tick && eng_last(s_q.tx)) begin
      s_d.dac_word = {s_q.tx.sh[14:0], s_q.din_s2};
      s_d.dac_new = 1'b1;
    end

    // apb slave: one access cycle, no wait states
    s_d.pready = setup;
    if (setup) begin
      s_d.prdata = rdata;
      s_d.pslverr = !rhit;
    end else if (!i_psel) begin
      s_d.prdata = 32'h0000_0000;
      s_d.pslverr = 1'b0;
    end
    if (wr) begin
      case (i_paddr)
        CSP_ADDR_CONTROL: s_d.ctrl = i_pwdata[7:0];
        CSP_ADDR_TX_DIVIDER_A: s_d.tx_div_a = i_pwdata[7:0];
        CSP_ADDR_TX_RATE_ADJUST: begin
          s_d.tx_adj = i_pwdata[7:0];
          s_d.tx_adj_pend = 1'b1;
        end
        CSP_ADDR_TX_DIVIDER_B: s_d.tx_div_b = i_pwdata[7:0];
        CSP_ADDR_RX_DIVIDER_A: s_d.rx_div_a = i_pwdata[7:0];
        CSP_ADDR_RX_RATE_ADJUST: begin
          s_d.rx_adj = i_pwdata[7:0];
          s_d.rx_adj_pend = 1'b1;
        end
        CSP_ADDR_RX_DIVIDER_B: s_d.rx_div_b = i_pwdata[7:0];
        CSP_ADDR_ADC_WORD: s_d.adc_word = i_pwdata[15:0];
        CSP_ADDR_STATUS: begin
          if (i_pwdata[CSP_CMD_SECONDARY_BIT]) begin
            s_d.sec_pend = 1'b1;
          end
        end
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      // phase starts in the low half so the first high half is full width
      s_q.ph <= CSP_SHIFT_PHASE_HIGH;
      s_q.tx.st <= CSP_ES_IDLE;
      s_q.tx.fs_n <= 1'b1;
      s_q.tx.eod_n <= 1'b1;
      s_q.rx.st <= CSP_ES_IDLE;
      s_q.rx.fs_n <= 1'b1;
      s_q.rx.eod_n <= 1'b1;
      s_q.ctrl <= CSP_RST_CONTROL;
      s_q.tx_div_a <= CSP_RST_DIVIDER_A;
      s_q.tx_div_b <= CSP_RST_DIVIDER_B;
      s_q.rx_div_a <= CSP_RST_DIVIDER_A;
      s_q.rx_div_b <= CSP_RST_DIVIDER_B;
      s_q.tx_adj <= CSP_RST_RATE_ADJUST;
      s_q.rx_adj <= CSP_RST_RATE_ADJUST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_shift_clock = s_q.shclk;
  assign o_serial_data_out = s_q.rx.sh[15];
  assign o_tx_frame_sync_n = s_q.tx.fs_n;
  assign o_rx_frame_sync_n = s_q.rx.fs_n;
  assign o_tx_transfer_done_n = s_q.tx.eod_n;
  assign o_rx_transfer_done_n = s_q.rx.eod_n;
  assign o_tx_filter_tick = s_q.tx_filt;
  assign o_rx_filter_tick = s_q.rx_filt;
  assign o_tx_convert = s_q.tx_conv;
  assign o_rx_convert = s_q.rx_conv;

endmodule // csp_serial_port
`default_nettype wire

// ==== csp_serial_port_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module csp_serial_port_chk (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_word_select,
  input wire logic o_shift_clock,
  input wire logic o_serial_data_out,
  input wire logic o_tx_frame_sync_n,
  input wire logic o_rx_frame_sync_n,
  input wire logic o_tx_transfer_done_n,
  input wire logic o_rx_transfer_done_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // ****************
  // serial link timing
  // ****************
  sclk_divide_a: assert property ($rose(o_shift_clock) |=>
    o_shift_clock ##1 !o_shift_clock ##1 !o_shift_clock ##1 o_shift_clock)
    else $error("shift clock not master over four");
  tx_on_edge_a: assert property ($changed({o_tx_frame_sync_n, o_tx_transfer_done_n}) |->
    $rose(o_shift_clock)) else $error("tx strobe moved off shift edge");
  rx_on_edge_a: assert property ($changed({o_rx_frame_sync_n, o_rx_transfer_done_n,
    o_serial_data_out}) |-> $rose(o_shift_clock)) else $error("rx line moved off shift edge");
  msb_before_a: assert property ($fell(o_rx_frame_sync_n) |->
    $stable(o_serial_data_out)) else $error("data out moved as rx sync fell");
  tx_word_done_a: assert property (i_word_select && $rose(o_tx_frame_sync_n) |->
    o_tx_transfer_done_n [*4] ##1 !o_tx_transfer_done_n [*4] ##1 o_tx_transfer_done_n)
    else $error("tx done pulse wrong in word mode");
  rx_word_done_a: assert property (i_word_select && $rose(o_rx_frame_sync_n) |->
    o_rx_transfer_done_n [*4] ##1 !o_rx_transfer_done_n [*4] ##1 o_rx_transfer_done_n)
    else $error("rx done pulse wrong in word mode");
  byte_gap_a: assert property (!i_word_select && $fell(o_tx_transfer_done_n) |->
    $rose(o_tx_frame_sync_n) ##16 $fell(o_tx_frame_sync_n)) else $error("byte gap wrong");
  byte_end_a: assert property (!i_word_select && $rose(o_tx_transfer_done_n) |->
    $rose(o_tx_frame_sync_n)) else $error("tx byte frame end wrong");
  rx_byte_end_a: assert property (!i_word_select && $rose(o_rx_transfer_done_n) |->
    $rose(o_rx_frame_sync_n)) else $error("rx byte frame end wrong");
  cover property (i_word_select && $fell(o_tx_transfer_done_n));
  cover property (!i_word_select && $fell(o_rx_transfer_done_n));
  cover property ($fell(o_rx_frame_sync_n));
endmodule // csp_serial_port_chk
bind csp_serial_port csp_serial_port_chk i_csp_serial_port_chk (.i_clock, .i_reset_n,
  .i_word_select, .o_shift_clock, .o_serial_data_out, .o_tx_frame_sync_n, .o_rx_frame_sync_n,
  .o_tx_transfer_done_n, .o_rx_transfer_done_n);
`default_nettype wire

// ==== test_csp_serial_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module test_csp_serial_port import csp_pkg::*; ;
  typedef struct packed {logic ws; logic [7:0] ctrl; logic [15:0] adc; logic [15:0] host;} csp_row_t;
  csp_row_t rows [4] = '{'{1'b1, 8'hE4, 16'hA5C3, 16'h3C5A}, '{1'b0, 8'hE4, 16'h81F0, 16'h0F18},
    '{1'b1, 8'hC4, 16'h1234, 16'hFEDC}, '{1'b0, 8'hC4, 16'h8001, 16'h7FFE}};
  logic [7:0] ra [8] = '{CSP_ADDR_CONTROL, CSP_ADDR_TX_DIVIDER_A, CSP_ADDR_TX_RATE_ADJUST,
    CSP_ADDR_TX_DIVIDER_B, CSP_ADDR_RX_DIVIDER_A, CSP_ADDR_RX_RATE_ADJUST, CSP_ADDR_RX_DIVIDER_B, 8'h28};
  logic [7:0] re [8] = '{8'hE4, 8'h12, 8'h01, 8'h24, 8'h12, 8'h01, 8'h24, 8'h00};
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_word_select = 1'b1;
  logic [15:0] host_word = 16'h0000;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, o_shift_clock, o_serial_data_out, sdin, err, sync_chk = 1'b0;
  logic o_tx_frame_sync_n, o_rx_frame_sync_n, o_tx_transfer_done_n, o_rx_transfer_done_n;
  logic [15:0] host_rx;
  logic tx_filt, rx_filt, tx_conv, rx_conv;
  int tick_diff = 0;
  int filt_run = 0;
  int filt_per_conv = 0;
  int n_mismatch = 0;
  int check_count = 0;
  int rx_seen = 0;
  int fs_diff = 0;
  int waited = 0;
  always #2 i_clock = ~i_clock;
  csp_serial_port i_csp_serial_port (.i_clock, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_word_select,
    .i_serial_data_in(sdin), .o_shift_clock, .o_serial_data_out, .o_tx_frame_sync_n,
    .o_rx_frame_sync_n, .o_tx_transfer_done_n, .o_rx_transfer_done_n,
    .o_tx_filter_tick(tx_filt), .o_rx_filter_tick(rx_filt), .o_tx_convert(tx_conv),
    .o_rx_convert(rx_conv));
  csp_host_model i_csp_host_model (.i_clock, .i_shift_clock(o_shift_clock),
    .i_tx_frame_sync_n(o_tx_frame_sync_n), .i_rx_frame_sync_n(o_rx_frame_sync_n),
    .i_serial_data_out(o_serial_data_out), .i_tx_word(host_word), .o_serial_data_in(sdin),
    .o_rx_word(host_rx));
  always @(posedge i_clock) begin
    if (!o_rx_frame_sync_n) rx_seen <= 1;
    if (sync_chk && o_rx_frame_sync_n !== o_tx_frame_sync_n) fs_diff <= fs_diff + 1;
    if (sync_chk && {rx_filt, rx_conv} !== {tx_filt, tx_conv}) tick_diff <= tick_diff + 1;
    if (tx_conv === 1'b1) begin
      filt_per_conv <= filt_run + 1;
      filt_run <= 0;
    end else if (tx_filt === 1'b1) begin
      filt_run <= filt_run + 1;
    end
  end
  // ****************
  // bus and wait helpers
  // ****************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bail(input string s);
    n_mismatch++;
    $display("MISMATCH %s expected answer seen timeout", s);
    finish_test();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    @(posedge i_clock);
    while (o_pready !== 1'b1) begin
      n++;
      if (n > 16) bail("pready");
      @(posedge i_clock);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wait_done(input logic rx);
    waited = 0;
    for (int v = 0; v < 2; v++) begin
      while ((rx ? o_rx_transfer_done_n : o_tx_transfer_done_n) !== v[0]) begin
        waited++;
        if (waited > 4000) bail("transfer done");
        @(posedge i_clock);
      end
    end
  endtask
  task automatic reset_dut();
    i_reset_n <= 1'b0;
    repeat (8) @(posedge i_clock);
    `CHK("idle in reset", 3'h5, {o_tx_frame_sync_n, o_shift_clock, o_rx_frame_sync_n})
    i_reset_n <= 1'b1;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    reset_dut();
    for (int k = 0; k < 4; k++) begin
      // both engines idle before the width pin moves
      wait_done(1'b0);
      wait_done(1'b1);
      i_word_select <= rows[k].ws;
      apb(1'b1, CSP_ADDR_CONTROL, {24'h00_0000, rows[k].ctrl});
      apb(1'b1, CSP_ADDR_ADC_WORD, {16'h0000, rows[k].adc});
      host_word <= rows[k].host;
      sync_chk <= rows[k].ctrl[CSP_CTRL_SYNC_BIT];
      wait_done(1'b0);
      wait_done(1'b1);
      wait_done(1'b1);
      sync_chk <= 1'b0;
      `CHK("host rx word", rows[k].adc, host_rx)
      apb(1'b0, CSP_ADDR_DAC_WORD, 32'h0000_0000);
      `CHK("dac word", {16'h0000, rows[k].host}, rd)
      `CHK("rx sync equal", 0, fs_diff)
      `CHK("rx ticks equal tx", 0, tick_diff)
      $display("mode row %0d done", k);
    end
    i_word_select <= 1'b1;
    apb(1'b1, CSP_ADDR_CONTROL, 32'h0000_00E4);
    wait_done(1'b0);
    rx_seen = 0;
    apb(1'b1, CSP_ADDR_STATUS, 32'h0000_0001);
    wait_done(1'b0);
    `CHK("rx sync in secondary", 0, rx_seen)
    $display("secondary exchange done");
    apb(1'b1, CSP_ADDR_TX_DIVIDER_A, 32'h0000_0055);
    reset_dut();
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, ra[k], 32'h0000_0000);
      `CHK("reset value", {24'h00_0000, re[k]}, rd)
      `CHK("slave error", k == 7, err)
    end
    wait_done(1'b0);
    wait_done(1'b0);
    `CHK("frame period", 648, waited)
    `CHK("filter ticks per conversion", 36, filt_per_conv)
    $display("reset values done");
    finish_test();
  end
endmodule // test_csp_serial_port
`default_nettype wire
